// ---- rtl/monitor_pkg.sv ----
// constants and types shared by the monitor register bank files
package monitor_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] CFG2_OFF = 8'h73;
  localparam logic [7:0] MASK1_OFF = 8'h74;
  localparam logic [7:0] MASK2_OFF = 8'h75;
  localparam logic [7:0] LOWBITS_OFF = 8'h76;
  // high-byte result registers of the four voltage readings
  localparam logic [7:0] HI_V25_OFF = 8'h20;
  localparam logic [7:0] HI_CORE_OFF = 8'h21;
  localparam logic [7:0] HI_OWN_OFF = 8'h22;
  localparam logic [7:0] HI_V5_OFF = 8'h23;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] CFG2_RST = 8'h00;
  localparam logic [7:0] MASK1_RST = 8'h00;
  localparam logic [7:0] MASK2_RST = 8'h00;
  localparam logic [9:0] RESULT_RST = 10'h000;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int FAN_SEL_LSB = 0;
  localparam int AVERAGING_BIT = 4;
  localparam int BYPASS_BIT = 5;
  localparam int SINGLE_BIT = 6;
  localparam int UNLOCK_BIT = 7;
  localparam int OVERTEMP_MASK_BIT = 1;
  localparam int CHAN_SEL_LSB = 5;
  localparam int NUM_VOLT = 4;

  // ************************************************************
  // single-channel select codes
  // ************************************************************
  typedef enum logic [2:0] {
    CH_V25 = 3'h0,
    CH_CORE = 3'h1,
    CH_OWN = 3'h2,
    CH_V5 = 3'h3,
    CH_V12 = 3'h4,
    CH_REMOTE1 = 3'h5,
    CH_LOCAL = 3'h6,
    CH_REMOTE2 = 3'h7
  } channel_t;

endpackage

// ---- rtl/result_if.sv ----
// one voltage reading travelling between the bank and its holding slice
`timescale 1ns/1ps
interface result_if;
  logic sample_valid;
  logic [9:0] sample;
  logic freeze;
  logic [9:0] value;

  modport owner (output sample_valid, output sample, output freeze, input value);
  modport slice (input sample_valid, input sample, input freeze, output value);
endinterface

// ---- rtl/result_slice.sv ----
// holding register for one 10-bit reading, stalled while frozen
`timescale 1ns/1ps
module result_slice (
  input wire logic sys_clk,
  input wire logic reset,
  result_if.slice res
);

  logic [9:0] value_ff;
  logic [9:0] nxt_value;

  // new samples land only while the reading is not frozen
  assign nxt_value = (res.sample_valid && !res.freeze) ? res.sample : value_ff;

  // ************************************************************
  // storage
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      value_ff <= monitor_pkg::RESULT_RST;
    end else begin
      value_ff <= nxt_value;
    end
  end

  assign res.value = value_ff;

  chk_frozen_hold: assert property (@(posedge sys_clk) disable iff (reset)
    res.freeze |=> value_ff == $past(value_ff))
    else $error("frozen reading changed");
endmodule

// ---- rtl/monitor_config_alert_mask.sv ----
// configuration, alert mask and extended-resolution register bank
`timescale 1ns/1ps
// What this block does
// - bits 3:0 of the configuration register pick two-wire (1) or pulse (0) sensing per fan.
// - configuration bit 4 set turns off measurement averaging.
// - configuration bit 5 set bypasses the attenuators on the four voltage inputs.
// - configuration bit 6 set puts the converter in single-channel mode.
// - in single-channel mode bits 7:5 of the fan 1 minimum high byte pick the channel.
// - first mask bits 0 to 6 suppress the alert for the seven voltage and temp channels.
// - second mask bits only act while bit 7 of the first mask is set.
// - second mask bit 0 suppresses the alert for the 12 V channel.
// - second mask bit 1 masks overtemperature and is read-only to the host.
// - second mask bits 2 to 5 suppress the alert for fan faults 1 to 4.
// - second mask bits 6 and 7 suppress the alert for diode faults on remotes 1 and 2.
// - the low-bits register shows the two LSBs of 2.5 V, core, own supply and 5 V.
// - reading the low-bits register freezes it and the high bytes until those are read.
// - the alert pin works only while the alert_enable input is high.
module monitor_config_alert_mask (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_ff,
  input wire logic [3:0] volt_valid,
  input wire logic [39:0] volt_sample,
  input wire logic [7:0] fan1_min_high,
  input wire logic test2_ext_start,
  input wire logic fan_pulse_input1,
  input wire logic [7:0] limit_viol,
  input wire logic overtemp,
  input wire logic [3:0] fan_fault,
  input wire logic [1:0] diode_fault,
  input wire logic alert_enable,
  output logic [3:0] fan_two_wire_ff,
  output logic averaging_disable_ff,
  output logic attenuator_bypass_ff,
  output logic single_channel_mode_ff,
  output monitor_pkg::channel_t convert_channel_ff,
  output logic convert_start_ff,
  output logic alert_n_ff,
  output logic alert_oe_ff
);

  logic [7:0] cfg2_ff;
  logic [7:0] mask1_ff;
  logic [7:0] mask2_ff;
  logic [3:0] freeze_ff;
  logic pulse_prev_ff;
  logic [7:0] nxt_rdata;
  logic [3:0] nxt_freeze;
  logic [9:0] volt_value [4];
  wire wr_cfg2 = reg_wr && (reg_addr == monitor_pkg::CFG2_OFF);
  wire wr_mask1 = reg_wr && (reg_addr == monitor_pkg::MASK1_OFF);
  wire wr_mask2 = reg_wr && (reg_addr == monitor_pkg::MASK2_OFF);
  wire rd_low = reg_rd && (reg_addr == monitor_pkg::LOWBITS_OFF);
  wire [3:0] rd_high;
  wire [7:0] low_bits;
  wire [7:0] m2_eff;
  wire [15:0] unmasked;
  wire any_unmasked;
  wire pulse_rise;

  // ************************************************************
  // reading slices
  // ************************************************************
  result_if res_if [monitor_pkg::NUM_VOLT] ();

  // per-channel freeze and high-byte read decode
  for (genvar g = 0; g < monitor_pkg::NUM_VOLT; g++) begin : g_volt
    assign rd_high[g] = reg_rd && (reg_addr == monitor_pkg::HI_V25_OFF + 8'(g));
    assign nxt_freeze[g] = rd_low ? 1'b1 : (rd_high[g] ? 1'b0 : freeze_ff[g]);
    assign res_if[g].sample_valid = volt_valid[g];
    assign res_if[g].sample = volt_sample[g*10 +: 10];
    assign res_if[g].freeze = freeze_ff[g] || rd_low;
    assign volt_value[g] = res_if[g].value;
    result_slice u_slice (
      .sys_clk(sys_clk),
      .reset(reset),
      .res(res_if[g])
    );
  end

  // low bits of the four readings, 2.5 V in the bottom pair
  assign low_bits = {volt_value[3][1:0], volt_value[2][1:0],
                     volt_value[1][1:0], volt_value[0][1:0]};

  // ************************************************************
  // register read mux
  // ************************************************************
  always_comb begin
    unique case (reg_addr)
      monitor_pkg::CFG2_OFF: nxt_rdata = cfg2_ff;
      monitor_pkg::MASK1_OFF: nxt_rdata = mask1_ff;
      monitor_pkg::MASK2_OFF: nxt_rdata = mask2_ff;
      monitor_pkg::LOWBITS_OFF: nxt_rdata = low_bits;
      monitor_pkg::HI_V25_OFF: nxt_rdata = volt_value[0][9:2];
      monitor_pkg::HI_CORE_OFF: nxt_rdata = volt_value[1][9:2];
      monitor_pkg::HI_OWN_OFF: nxt_rdata = volt_value[2][9:2];
      monitor_pkg::HI_V5_OFF: nxt_rdata = volt_value[3][9:2];
      default: nxt_rdata = monitor_pkg::UNMAPPED_READ;
    endcase
  end

  // ************************************************************
  // alert gating
  // ************************************************************
  // second mask acts only while unlocked
  assign m2_eff = mask1_ff[monitor_pkg::UNLOCK_BIT] ? mask2_ff : 8'h00;
  assign unmasked[6:0] = limit_viol[6:0] & ~mask1_ff[6:0];
  assign unmasked[7] = limit_viol[7] & ~m2_eff[0];
  assign unmasked[8] = overtemp & ~m2_eff[monitor_pkg::OVERTEMP_MASK_BIT];
  assign unmasked[12:9] = fan_fault & ~m2_eff[5:2];
  assign unmasked[14:13] = diode_fault & ~m2_eff[7:6];
  assign unmasked[15] = 1'b0;
  assign any_unmasked = |unmasked;
  assign pulse_rise = fan_pulse_input1 && !pulse_prev_ff;

  // ************************************************************
  // host registers
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg2_ff <= monitor_pkg::CFG2_RST;
      mask1_ff <= monitor_pkg::MASK1_RST;
      mask2_ff <= monitor_pkg::MASK2_RST;
    end else begin
      if (wr_cfg2) begin
        cfg2_ff <= reg_wdata;
      end
      if (wr_mask1) begin
        mask1_ff <= reg_wdata;
      end
      if (wr_mask2) begin
        mask2_ff <= {reg_wdata[7:2], mask2_ff[1], reg_wdata[0]};
      end
    end
  end

  // freeze flags and read data
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      freeze_ff <= 4'h0;
      reg_rdata_ff <= 8'h00;
    end else begin
      freeze_ff <= nxt_freeze;
      reg_rdata_ff <= reg_rd ? nxt_rdata : reg_rdata_ff;
    end
  end

  // ************************************************************
  // outputs to the converter, fan sensing and alert pin
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fan_two_wire_ff <= 4'h0;
      averaging_disable_ff <= 1'b0;
      attenuator_bypass_ff <= 1'b0;
      single_channel_mode_ff <= 1'b0;
      convert_channel_ff <= monitor_pkg::CH_V25;
      convert_start_ff <= 1'b0;
      pulse_prev_ff <= 1'b0;
      alert_n_ff <= 1'b1;
      alert_oe_ff <= 1'b0;
    end else begin
      fan_two_wire_ff <= cfg2_ff[monitor_pkg::FAN_SEL_LSB +: 4];
      averaging_disable_ff <= cfg2_ff[monitor_pkg::AVERAGING_BIT];
      attenuator_bypass_ff <= cfg2_ff[monitor_pkg::BYPASS_BIT];
      single_channel_mode_ff <= cfg2_ff[monitor_pkg::SINGLE_BIT];
      // all eight codes are legal, 000 and 111 included
      convert_channel_ff <= monitor_pkg::channel_t'(
        fan1_min_high[monitor_pkg::CHAN_SEL_LSB +: 3]);
      pulse_prev_ff <= fan_pulse_input1;
      convert_start_ff <= pulse_rise && test2_ext_start &&
        cfg2_ff[monitor_pkg::SINGLE_BIT];
      alert_n_ff <= !(alert_enable && any_unmasked);
      alert_oe_ff <= alert_enable;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  chk_fan_select: assert property (@(posedge sys_clk) disable iff (reset)
    wr_cfg2 |=> ##1 fan_two_wire_ff == $past(reg_wdata[3:0], 2))
    else $error("fan sensing select not taken from config");
  chk_averaging_off: assert property (@(posedge sys_clk) disable iff (reset)
    wr_cfg2 ##1 !wr_cfg2 |=> averaging_disable_ff == $past(reg_wdata[4], 2))
    else $error("averaging control wrong");
  chk_attenuator_bypass_bypass: assert property (@(posedge sys_clk) disable iff (reset)
    ##1 attenuator_bypass_ff == $past(cfg2_ff[5]))
    else $error("attenuator bypass wrong");
  chk_single_mode: assert property (@(posedge sys_clk) disable iff (reset)
    ##1 single_channel_mode_ff == $past(cfg2_ff[6]))
    else $error("single channel mode wrong");
  chk_chan_code: assert property (@(posedge sys_clk) disable iff (reset)
    ##1 convert_channel_ff == $past(fan1_min_high[7:5]))
    else $error("channel select wrong");
  chk_ext_start: assert property (@(posedge sys_clk) disable iff (reset)
    convert_start_ff |-> $past(test2_ext_start) && $past(cfg2_ff[6])
      && $past(fan_pulse_input1, 1)
      && !$past(fan_pulse_input1, 2))
    else $error("conversion start without external edge");
  chk_first_mask: assert property (@(posedge sys_clk) disable iff (reset)
    alert_enable && ((limit_viol[6:0] & ~mask1_ff[6:0]) != 7'h00) |=> !alert_n_ff)
    else $error("unmasked channel did not alert");
  chk_unlock_gate: assert property (@(posedge sys_clk) disable iff (reset)
    alert_enable && !mask1_ff[7] && (fan_fault != 4'h0) |=> !alert_n_ff)
    else $error("second mask acted while locked");
  chk_ovt_readonly: assert property (@(posedge sys_clk) disable iff (reset)
    wr_mask2 |=> mask2_ff[1] == $past(mask2_ff[1]))
    else $error("overtemp mask bit changed by write");
  chk_low_bits: assert property (@(posedge sys_clk) disable iff (reset)
    rd_low |=> reg_rdata_ff == $past(low_bits))
    else $error("low bits read wrong");
  chk_freeze_set: assert property (@(posedge sys_clk) disable iff (reset)
    rd_low |=> freeze_ff == 4'hF ##1 (freeze_ff != 4'h0 || $past(|rd_high)))
    else $error("low bits read did not freeze readings");
  chk_alert_quiet: assert property (@(posedge sys_clk) disable iff (reset)
    !alert_enable |=> alert_n_ff && !alert_oe_ff)
    else $error("alert active while pin disabled");
  chk_alert_clear: assert property (@(posedge sys_clk) disable iff (reset)
    !any_unmasked |=> alert_n_ff)
    else $error("alert without unmasked condition");

  cov_alert: cover property (@(posedge sys_clk) disable iff (reset) !alert_n_ff);
  cov_freeze: cover property (@(posedge sys_clk) disable iff (reset) rd_low ##[1:20] rd_high[0]);
  cov_ext_start: cover property (@(posedge sys_clk) disable iff (reset) convert_start_ff);
endmodule

// ---- tb/host_model.sv ----
// host model driving the register strobes of the monitor bank
`timescale 1ns/1ps
module host_model (
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata_ff,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd
);
  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // one write strobe, data scrambled once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // one read strobe, data taken after the answer edge settles
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata_ff;
  endtask
endmodule

// ---- tb/tb.sv ----
// self-checking bench of the monitor configuration and alert mask bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_ff, m1, m2;
  logic reg_wr, reg_rd, convert_start_ff, alert_n_ff, alert_oe_ff;
  logic [3:0] volt_valid = 4'h0, fan_fault = 4'h0;
  logic [39:0] volt_sample = 40'h0, s0, s1;
  logic [7:0] fan1_min_high = 8'h00, limit_viol = 8'h00;
  logic test2_ext_start = 1'b0, fan_pulse_input1 = 1'b0, overtemp = 1'b0, alert_enable = 1'b0;
  logic [1:0] diode_fault = 2'h0;
  logic [3:0] fan_two_wire_ff;
  logic averaging_disable_ff, attenuator_bypass_ff, single_channel_mode_ff;
  monitor_pkg::channel_t convert_channel_ff;
  int checked = 0;
  int bad_count = 0;
  logic [31:0] seed = 32'hA066;
  logic [15:0] src;
  // device under test and host partner
  monitor_config_alert_mask monitor_config_alert_mask_inst (.sys_clk, .reset, .reg_addr,
    .reg_wr, .reg_wdata, .reg_rd, .reg_rdata_ff, .volt_valid, .volt_sample, .fan1_min_high,
    .test2_ext_start, .fan_pulse_input1, .limit_viol, .overtemp, .fan_fault, .diode_fault,
    .alert_enable, .fan_two_wire_ff, .averaging_disable_ff, .attenuator_bypass_ff,
    .single_channel_mode_ff, .convert_channel_ff, .convert_start_ff, .alert_n_ff,
    .alert_oe_ff);
  host_model host_model_inst (.sys_clk, .reg_rdata_ff, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
  // clock and watchdog
  always #50 sys_clk = ~sys_clk;
  initial begin
    #2_000_000;
    bad_count++;
    results();
  end
  // next value of the stimulus shift register
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // low pairs of the four readings in extended register order
  function automatic logic [7:0] lowb(input logic [39:0] s);
    return {s[31:30], s[21:20], s[11:10], s[1:0]};
  endfunction
  // expected alert pin from both masks and a one-hot fault source
  function automatic logic exp_alert_n(input logic [7:0] a, input logic [7:0] b,
    input logic [15:0] s, input logic en);
    logic [7:0] e2;
    e2 = a[7] ? (b & 8'hFD) : 8'h00;
    return !(en && (|(s[6:0] & ~a[6:0]) || (s[7] && !e2[0]) || s[8] ||
      |(s[12:9] & ~e2[5:2]) || |(s[14:13] & ~e2[7:6])));
  endfunction
  // wait edges, then let their updates land
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // read one register and compare
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_model_inst.rd(a, d);
    `CHK(nm, e, d)
  endtask
  // one sample strobe on all four voltage channels
  task automatic load(input logic [39:0] s);
    @(posedge sys_clk);
    volt_valid <= 4'hF;
    volt_sample <= s;
    @(posedge sys_clk);
    volt_valid <= 4'h0;
  endtask
  // verdict and end of run
  task results;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    tick(1);
    `CHK("alert_oe", 1'b0, alert_oe_ff)
    rchk("cfg", monitor_pkg::CFG2_OFF, monitor_pkg::CFG2_RST);
    rchk("mask1", monitor_pkg::MASK1_OFF, monitor_pkg::MASK1_RST);
    rchk("mask2", monitor_pkg::MASK2_OFF, monitor_pkg::MASK2_RST);
    rchk("unmapped", 8'h10, monitor_pkg::UNMAPPED_READ);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      m1 = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : seed[7:0];
      host_model_inst.wr(monitor_pkg::CFG2_OFF, m1);
      tick(2);
      `CHK("fan_sel", m1[3:0], fan_two_wire_ff)
      `CHK("averaging", m1[4], averaging_disable_ff)
      `CHK("bypass", m1[5], attenuator_bypass_ff)
      `CHK("single", m1[6], single_channel_mode_ff)
      rchk("cfg", monitor_pkg::CFG2_OFF, m1);
    end
    for (int c = 0; c < 8; c++) begin
      @(posedge sys_clk);
      fan1_min_high <= {c[2:0], 5'h15};
      tick(1);
      `CHK("chan", c[2:0], convert_channel_ff)
    end
    host_model_inst.wr(monitor_pkg::CFG2_OFF, 8'h40);
    for (int t = 0; t < 2; t++) begin
      @(posedge sys_clk);
      test2_ext_start <= t[0];
      fan_pulse_input1 <= 1'b0;
      @(posedge sys_clk);
      fan_pulse_input1 <= 1'b1;
      tick(1);
      `CHK("start_pulse", t[0], convert_start_ff)
      tick(1);
      `CHK("start_end", 1'b0, convert_start_ff)
    end
    // external edge with single-channel mode off must not start
    host_model_inst.wr(monitor_pkg::CFG2_OFF, 8'h00);
    @(posedge sys_clk);
    fan_pulse_input1 <= 1'b0;
    @(posedge sys_clk);
    fan_pulse_input1 <= 1'b1;
    tick(1);
    `CHK("start_gated", 1'b0, convert_start_ff)
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      m1 = seed[7:0];
      m2 = seed[15:8];
      src = 16'h0001 << seed[19:16];
      host_model_inst.wr(monitor_pkg::MASK1_OFF, m1);
      host_model_inst.wr(monitor_pkg::MASK2_OFF, m2);
      @(posedge sys_clk);
      limit_viol <= src[7:0];
      overtemp <= src[8];
      fan_fault <= src[12:9];
      diode_fault <= src[14:13];
      alert_enable <= seed[20] | seed[21];
      tick(2);
      `CHK("alert_n", exp_alert_n(m1, m2, src, alert_enable), alert_n_ff)
      `CHK("alert_oe", alert_enable, alert_oe_ff)
      rchk("mask2", monitor_pkg::MASK2_OFF, m2 & 8'hFD);
    end
    seed = lfsr(seed);
    s0 = {seed[7:0], seed};
    seed = lfsr(seed);
    s1 = {seed, ~seed[7:0]};
    load(s0);
    rchk("low", monitor_pkg::LOWBITS_OFF, lowb(s0));
    load(s1);
    rchk("hi0", monitor_pkg::HI_V25_OFF, s0[9:2]);
    load(s1);
    rchk("low", monitor_pkg::LOWBITS_OFF, {s0[31:30], s0[21:20], s0[11:10], s1[1:0]});
    for (int g = 1; g < 4; g++) begin
      rchk("hi", 8'(monitor_pkg::HI_V25_OFF + g), s0[g * 10 + 2 +: 8]);
    end
    rchk("hi0", monitor_pkg::HI_V25_OFF, s1[9:2]);
    load(s1);
    host_model_inst.wr(monitor_pkg::LOWBITS_OFF, 8'h5A);
    rchk("low", monitor_pkg::LOWBITS_OFF, lowb(s1));
    results();
  end
endmodule
